/* verilog/peripheral_module_disable.sv */
// Purpose: Per-peripheral disable, reset hold, output and register isolation
// Assumes: One clock, synchronous active-low reset, AXI4-Lite single beats
// Notes:   Memory wake time is shown in status, software waits on it

`timescale 1ns/1ps

// Functional notes
// - Reset clears every disable control.
// - Disabled peripheral held in reset.
// - Disabled peripheral registers ignore writes, read zero.
// - Disabled peripheral outputs forced inactive.
// - Clearing bit releases peripheral at power-on values.
// - Clock gate bit stops peripheral clock network.
// - Bit 7 gates clock network, resets 0.
// - Bit 2 blocks memory and controller access.
// - Bit 1 disables reference clock output.
// - Bit 0 disables pin-change interrupt logic.
module peripheral_module_disable
	import pmd_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int WAKE_W = 8,
	parameter int WAKE_CYC = MEM_WAKE_CYC
)(
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// AXI4-Lite write channels
	input  wire logic [ADDR_W-1:0]    awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	// AXI4-Lite read channels
	input  wire logic [ADDR_W-1:0]    araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	// Peripheral control
	output periph_ctl_t               periph,
	// Register and memory access isolation
	input  wire access_t              acc_req,
	output access_t                   acc_out,
	input  wire logic [NP-1:0][7:0]   sfr_rdata_in,
	output logic [NP-1:0][7:0]        sfr_rdata_out,
	input  wire logic [7:0]           mem_rdata_in,
	output logic [7:0]                mem_rdata_out
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Control bits mapped to peripheral slots
	function automatic logic [NP-1:0] off_mask(input logic [7:0] c);
		off_mask = {c[BIT_VREF], c[BIT_MEM], c[BIT_REFCLK], c[BIT_PINIRQ]};
	endfunction : off_mask

	// Word address match within the bus width
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [15:0] target);
		addr_hit = (a[ADDR_W-1:2] == target[ADDR_W-1:2]);
	endfunction : addr_hit

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]        ctrl0;
	logic [WAKE_W-1:0] wake_cnt;
	logic              mem_waking;

	// ----------------------------------------------------------------
	// Write path
	// ----------------------------------------------------------------

	// Address and data taken together once the response slot is free
	logic wr_fire;
	logic wr_ctrl;
	logic wr_stat;
	assign awready = awvalid & wvalid & ~bvalid;
	assign wready  = awready;
	assign wr_fire = awready;
	assign wr_ctrl = addr_hit(awaddr, ADDR_CTRL0);
	assign wr_stat = addr_hit(awaddr, ADDR_STATUS);

	// Next control value, unimplemented bits dropped
	// reserved bits masked
	logic [7:0] next_ctrl0;
	assign next_ctrl0 = wdata[7:0] & CTRL0_MASK;

	// Control register, all modules on after reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl0 <= RST_CTRL0;
		else if (wr_fire && wr_ctrl && wstrb[0])
			ctrl0 <= next_ctrl0;
	end

	// Write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid <= 1'b1;
			bresp  <= (wr_ctrl || wr_stat) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic        rd_fire;
	logic        rd_ctrl;
	logic        rd_stat;
	logic [31:0] stat_word;
	logic [31:0] next_rdata;
	assign arready = ~rvalid;
	assign rd_fire = arvalid & arready;
	assign rd_ctrl = addr_hit(araddr, ADDR_CTRL0);
	assign rd_stat = addr_hit(araddr, ADDR_STATUS);

	// Status word reflects live gating state
	assign stat_word = (32'(periph.hold_rst) << ST_OFF_LSB)
		| (32'({~periph.sysclk_en}) << ST_CLK_STOP)
		| (32'(mem_waking) << ST_MEM_WAKE);
	assign next_rdata = rd_ctrl ? {24'h0, ctrl0} : (rd_stat ? stat_word : 32'h0);

	// Read answer, data held until taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid <= 1'b1;
			rdata  <= next_rdata;
			rresp  <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rready)
			rvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Memory wake timer
	// ----------------------------------------------------------------

	// Counts the settle time after the memory module is re-enabled
	// wake window shown
	logic mem_off;
	logic mem_release;
	assign mem_off     = ctrl0[BIT_MEM];
	assign mem_release = wr_fire && wr_ctrl && wstrb[0] && mem_off && !next_ctrl0[BIT_MEM];
	assign mem_waking  = (wake_cnt != '0);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wake_cnt <= '0;
		else if (mem_release)
			wake_cnt <= WAKE_W'(WAKE_CYC);
		else if (mem_waking)
			wake_cnt <= wake_cnt - 1'b1;
	end

	// ----------------------------------------------------------------
	// Peripheral gating
	// ----------------------------------------------------------------

	// Reset hold and output gating straight from the control flops
	// vref slot bit 6
	assign periph.hold_rst  = off_mask(ctrl0);
	assign periph.out_en    = ~off_mask(ctrl0);
	assign periph.sysclk_en = ~ctrl0[BIT_SYSCLK];

	// Register isolation of disabled peripherals
	// writes dropped, reads zero
	assign acc_out.wr = acc_req.wr & ~periph.hold_rst;
	always_comb
	begin
		for (int i = 0; i < NP; i++)
			sfr_rdata_out[i] = periph.hold_rst[i] ? 8'h00 : sfr_rdata_in[i];
	end

	// Memory access blocking
	// memory accesses blocked
	assign acc_out.mem_rd = acc_req.mem_rd & ~mem_off;
	assign acc_out.mem_wr = acc_req.mem_wr & ~mem_off;
	assign mem_rdata_out  = mem_off ? 8'h00 : mem_rdata_in;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Write of control reaches the gates one edge later
	logic [7:0] last_wr;
	logic       last_wr_ok;
	always_ff @(posedge aclk)
	begin
		last_wr    <= next_ctrl0;
		last_wr_ok <= aresetn && wr_fire && wr_ctrl && wstrb[0];
	end

	reset_clear_a: assert property (disable iff (1'b0)
		!aresetn |=> (ctrl0 == 8'h00) && periph.sysclk_en && (periph.hold_rst == '0))
		else $error("controls not cleared by reset");

	hold_reset_a: assert property (
		last_wr_ok |-> periph.hold_rst == off_mask(last_wr))
		else $error("reset hold does not follow written bits");

	sfr_isolate_a: assert property (
		((acc_out.wr & periph.hold_rst) == '0)
		and (!periph.hold_rst[P_REFCLK] || sfr_rdata_out[P_REFCLK] == 8'h00))
		else $error("disabled peripheral register reachable");

	out_gate_a: assert property (
		((periph.out_en & periph.hold_rst) == '0)
		&& (periph.out_en == ~{ctrl0[BIT_VREF], ctrl0[BIT_MEM], ctrl0[BIT_REFCLK], ctrl0[BIT_PINIRQ]}))
		else $error("disabled peripheral output active");

	release_a: assert property (
		$fell(periph.hold_rst[P_VREF]) && $past(aresetn) |-> periph.out_en[P_VREF] && $past(wr_fire))
		else $error("release without write or output stuck");

	clock_gate_a: assert property (
		last_wr_ok |-> periph.sysclk_en == !last_wr[BIT_SYSCLK])
		else $error("clock gate bit wrong");

	mem_block_a: assert property (
		mem_off |-> !acc_out.mem_rd && !acc_out.mem_wr && mem_rdata_out == 8'h00)
		else $error("memory access while disabled");

	rsvd_zero_a: assert property (
		rd_fire && rd_ctrl |=> rvalid && rdata[5:3] == 3'h0 && rdata[31:8] == 24'h0)
		else $error("reserved bits read nonzero");

	mem_wake_a: assert property (
		mem_release |=> mem_waking [*8])
		else $error("memory wake window too short");

	// Bus answers: one cycle latency, held until taken
	b_answer_a: assert property (
		wr_fire |=> bvalid)
		else $error("write response missing");

	b_hold_a: assert property (
		bvalid |=> (bvalid || $past(bready)) && $stable(bresp))
		else $error("write response dropped early");

	r_answer_a: assert property (
		rd_fire |=> rvalid)
		else $error("read response missing");

	r_hold_a: assert property (
		rvalid |=> (rvalid || $past(rready)) && $stable(rdata) && $stable(rresp))
		else $error("read response dropped early");

	aw_block_a: assert property (
		bvalid |-> !awready && !wready)
		else $error("second write taken while response pending");

	// Unmapped addresses answer with an error
	b_error_a: assert property (
		wr_fire && !wr_ctrl && !wr_stat |=> bresp == RESP_SLVERR)
		else $error("unmapped write not refused");

	rd_unmapped_a: assert property (
		rd_fire && !rd_ctrl && !rd_stat |=> rresp == RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");

	st_rsvd_a: assert property (
		rd_fire && rd_stat |=> rdata[7:5] == 3'h0 && rdata[31:9] == 23'h0)
		else $error("status spare bits nonzero");

	// Slot mapping of control bits 6, 1 and 0
	vref_slot_a: assert property (
		periph.hold_rst[P_VREF] == ctrl0[BIT_VREF] && periph.out_en[P_VREF] == !ctrl0[BIT_VREF])
		else $error("vref slot does not follow bit 6");

	refclk_slot_a: assert property (
		periph.hold_rst[P_REFCLK] == ctrl0[BIT_REFCLK] && periph.out_en[P_REFCLK] == !ctrl0[BIT_REFCLK])
		else $error("refclk slot does not follow bit 1");

	pinirq_slot_a: assert property (
		periph.hold_rst[P_PINIRQ] == ctrl0[BIT_PINIRQ] && periph.out_en[P_PINIRQ] == !ctrl0[BIT_PINIRQ])
		else $error("pin-change slot does not follow bit 0");

	// Control register changes only on a lane 0 write
	ctrl_hold_a: assert property (
		aresetn && !(wr_fire && wr_ctrl && wstrb[0]) |=> $stable(ctrl0))
		else $error("control changed without a write");

	// Wake timer load and countdown
	wake_load_a: assert property (
		mem_release |=> wake_cnt == WAKE_W'(WAKE_CYC))
		else $error("wake timer not loaded");

	wake_step_a: assert property (
		mem_waking && !mem_release |=> wake_cnt == $past(wake_cnt) - 1'b1)
		else $error("wake timer not counting down");

	disable_cover_c:  cover property (last_wr_ok ##1 periph.hold_rst[P_MEM]);
	status_cover_c:   cover property (rd_fire && rd_stat);
	reenable_cover_c: cover property (mem_release ##1 mem_waking);
	clkstop_cover_c:  cover property ($fell(periph.sysclk_en));
	unmapped_cover_c: cover property (rvalid && rresp == RESP_SLVERR);

endmodule : peripheral_module_disable

/* verilog/pmd_pkg.sv */
// Purpose: Shared constants and carriers for the peripheral disable controller
// Assumes: 32-bit AXI4-Lite register bus, 200 MHz system clock
// Notes:   Register index kept as printed; byte address is four times the index

package pmd_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_CTRL0   = 16'h0796;
	localparam logic [15:0] IDX_STATUS  = 16'h0797;
	localparam logic [15:0] ADDR_CTRL0  = {IDX_CTRL0[13:0], 2'b00};
	localparam logic [15:0] ADDR_STATUS = {IDX_STATUS[13:0], 2'b00};
	localparam logic [7:0]  RST_CTRL0   = 8'h00;

	// ----------------------------------------------------------------
	// Control register 0 fields
	// ----------------------------------------------------------------
	localparam int BIT_SYSCLK = 7;
	localparam int BIT_VREF   = 6;
	localparam int BIT_MEM    = 2;
	localparam int BIT_REFCLK = 1;
	localparam int BIT_PINIRQ = 0;
	localparam logic [7:0] CTRL0_MASK = 8'hC7;

	// Peripheral slots on the gating ports
	localparam int NP        = 4;
	localparam int P_PINIRQ  = 0;
	localparam int P_REFCLK  = 1;
	localparam int P_MEM     = 2;
	localparam int P_VREF    = 3;

	// Status register fields
	localparam int ST_OFF_LSB   = 0;
	localparam int ST_CLK_STOP  = 4;
	localparam int ST_MEM_WAKE  = 8;

	// ----------------------------------------------------------------
	// Bus answers and timing
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int MEM_WAKE_NS    = 1000;
	localparam int MEM_WAKE_CYC   = (MEM_WAKE_NS * 1000) / CLK_PERIOD_PS;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NP-1:0] hold_rst;
		logic [NP-1:0] out_en;
		logic          sysclk_en;
	} periph_ctl_t;

	typedef struct packed {
		logic [NP-1:0] wr;
		logic          mem_rd;
		logic          mem_wr;
	} access_t;

endpackage : pmd_pkg

/* tb/periph_model.sv */
// Purpose: Peripheral slots behind the disable controller
// Assumes: Slot registers sit at a power-on value while held in reset
// Notes:   A gated write turns a slot register to the inverse value
`timescale 1ns/1ps
module periph_model
	import pmd_pkg::*;
#(
	parameter logic [7:0] POR_VAL = 8'h5A,
	parameter logic [7:0] MEM_VAL = 8'h3C
)(
	// Clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// Controls from the block
	input  wire periph_ctl_t        periph,
	input  wire access_t            acc_out,
	// Data toward the block
	output logic [NP-1:0][7:0]      sfr_rdata_in,
	output logic [7:0]              mem_rdata_in
);
	always_ff @(posedge aclk)
	begin
		for (int i = 0; i < NP; i++)
		begin
			if (!aresetn || periph.hold_rst[i])
				sfr_rdata_in[i] <= POR_VAL;
			else if (acc_out.wr[i])
				sfr_rdata_in[i] <= ~POR_VAL;
		end
	end
	assign mem_rdata_in = MEM_VAL;
endmodule : periph_model

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the peripheral disable controller
// Assumes: 200 MHz clock, AXI4-Lite master tasks below
// Notes:   Slot model returns 5A at power-on, A5 once written
`timescale 1ns/1ps
module tb_top;
	import pmd_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	periph_ctl_t periph;
	access_t acc_req, acc_out;
	logic [NP-1:0][7:0] sfr_in, sfr_out;
	logic [7:0] mem_in, mem_out;
	int bad_count, n_compared;
	peripheral_module_disable #(.WAKE_CYC(10)) peripheral_module_disable_inst (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .periph(periph),
		.acc_req(acc_req), .acc_out(acc_out), .sfr_rdata_in(sfr_in), .sfr_rdata_out(sfr_out),
		.mem_rdata_in(mem_in), .mem_rdata_out(mem_out));
	periph_model periph_model_inst (.aclk(aclk), .aresetn(aresetn), .periph(periph), .acc_out(acc_out),
		.sfr_rdata_in(sfr_in), .mem_rdata_in(mem_in));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Write with address and data offered together
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do @(negedge aclk); while (awready !== 1'b1);
		@(posedge aclk);
		awvalid <= 1'b0; wvalid <= 1'b0;
		do @(negedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr
	task automatic rd_reg(input logic [15:0] a);
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		rd = rdata; rs = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd_reg
	task automatic t_reset;
		rd_reg(ADDR_CTRL0);
		chk(rd, 32'h0);
		chk(periph, {4'h0, 4'hF, 1'b1});
	endtask : t_reset
	task automatic t_fields;
		wr(ADDR_CTRL0, 32'h0000_00FF);
		chk(rs, RESP_OKAY);
		rd_reg(ADDR_CTRL0);
		chk(rd, 32'h0000_00C7);
		chk(periph, {4'hF, 4'h0, 1'b0});
		rd_reg(ADDR_STATUS);
		chk(rd, 32'h0000_001F);
	endtask : t_fields
	task automatic t_slots;
		int bits [4];
		bits = '{BIT_PINIRQ, BIT_REFCLK, BIT_MEM, BIT_VREF};
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_CTRL0, 32'h1 << bits[i]);
			@(negedge aclk);
			chk(periph, {4'h1 << i, ~(4'h1 << i), 1'b1});
		end
	endtask : t_slots
	task automatic t_isolate;
		wr(ADDR_CTRL0, 32'h0);
		@(posedge aclk);
		acc_req <= '{wr: 4'hF, mem_rd: 1'b1, mem_wr: 1'b1};
		@(negedge aclk);
		chk(acc_out, 6'h3F);
		@(posedge aclk);
		acc_req <= '{wr: 4'h0, mem_rd: 1'b0, mem_wr: 1'b0};
		@(negedge aclk);
		chk(sfr_out, {4{8'hA5}});
		wr(ADDR_CTRL0, 32'h0000_0047);
		@(posedge aclk);
		acc_req <= '{wr: 4'hF, mem_rd: 1'b1, mem_wr: 1'b1};
		@(negedge aclk);
		chk(acc_out, 6'h0);
		chk(sfr_out, 32'h0);
		chk(mem_out, 8'h0);
		@(posedge aclk);
		acc_req <= '{wr: 4'h0, mem_rd: 1'b0, mem_wr: 1'b0};
		wr(ADDR_CTRL0, 32'h0);
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk(sfr_out, {4{8'h5A}});
		chk(mem_out, 8'h3C);
	endtask : t_isolate
	task automatic t_unmapped;
		rd_reg(16'h0010);
		chk(rs, RESP_SLVERR);
		chk(rd, 32'h0);
		wr(16'h0010, 32'h0000_00FF);
		chk(rs, RESP_SLVERR);
	endtask : t_unmapped
	// Memory wake window polled by software, status writes and lane 0
	task automatic t_wake;
		int n;
		wr(ADDR_CTRL0, 32'h0000_0004);
		rd_reg(ADDR_STATUS);
		chk(rd, 32'h0000_0004);
		wr(ADDR_CTRL0, 32'h0);
		rd_reg(ADDR_STATUS);
		chk(rd, 32'h0000_0100);
		n = 0;
		while (rd[ST_MEM_WAKE] === 1'b1 && n < 20)
		begin
			rd_reg(ADDR_STATUS);
			n++;
		end
		chk(n < 20, 32'h1);
		chk(rd, 32'h0);
		chk(mem_out, 8'h3C);
		wr(ADDR_STATUS, 32'hFFFF_FFFF);
		chk(rs, RESP_OKAY);
		wstrb <= 4'hE;
		wr(ADDR_CTRL0, 32'h0000_00C7);
		wstrb <= 4'hF;
		rd_reg(ADDR_CTRL0);
		chk(rd, 32'h0);
	endtask : t_wake
	// Reset in mid-run with modules disabled
	task automatic t_rerst;
		wr(ADDR_CTRL0, 32'h0000_00C7);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(ADDR_CTRL0);
		chk(rd, 32'h0);
		chk(periph, {4'h0, 4'hF, 1'b1});
	endtask : t_rerst
	task automatic final_report;
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	initial
	begin
		#20000;
		bad_count++;
		final_report;
	end
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		acc_req = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_fields;
		t_slots;
		t_isolate;
		t_unmapped;
		t_wake;
		t_rerst;
		final_report;
	end
endmodule : tb_top
